// >>> spd_checker.sv
// Port assertions for the power-down and termination block
module spd_checker #(
  parameter DQ_W = 16,
  parameter DM_W = 2
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            cke,
  input wire logic            odt,
  input wire logic            cmd_nop,
  input wire logic            banks_open,
  input wire logic            op_busy,
  input wire logic            power_down_state,
  input wire logic            cmd_rx_on,
  input wire logic            buf_on,
  input wire logic            dll_on,
  input wire logic            any_cmd_ok,
  input wire logic            dll_cmd_ok,
  input wire logic [DQ_W-1:0] rtt_dq_on,
  input wire logic [1:0]      rtt_dqs_on,
  input wire logic [DM_W-1:0] rtt_dm_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Entry needs CKE low and the pending row operation finished
  property p_ent; $rose(power_down_state) |-> !cke && !$past(op_busy); endproperty
  a_ent: assert property (p_ent) else $error("bad entry");
  property p_apd; $rose(power_down_state) && $past(banks_open) |-> dll_on; endproperty
  a_apd: assert property (p_apd) else $error("dll off in active down");
  // Buffers shut whenever down; receivers shut only once CKE has been low for two cycles
  property p_buf; power_down_state |-> !buf_on; endproperty
  a_buf: assert property (p_buf) else $error("buffers on");
  property p_rx; $fell(cmd_rx_on) |-> !cke && !$past(cke); endproperty
  a_rx: assert property (p_rx) else $error("receivers off early");
  // Exit gate stays shut for the exit latency, then opens within a bound
  sequence s_xp; !any_cmd_ok [*2] ##[1:8] any_cmd_ok; endsequence
  property p_ext; $fell(power_down_state) |-> cke && cmd_nop ##1 s_xp; endproperty
  a_ext: assert property (p_ext) else $error("bad exit");
  property p_slw; $fell(power_down_state) && !$past(dll_on) |=> !dll_cmd_ok [*8]; endproperty
  a_slw: assert property (p_slw) else $error("slow exit too soon");
  // Termination off the cycle after the pin is low, same on every line
  property p_odt; !odt |=> rtt_dq_on == '0; endproperty
  a_odt: assert property (p_odt) else $error("rtt without pin");
  property p_all; rtt_dqs_on == {2{rtt_dq_on[0]}} && rtt_dm_on == {DM_W{rtt_dq_on[0]}}
    && rtt_dq_on == {DQ_W{rtt_dq_on[0]}}; endproperty
  a_all: assert property (p_all) else $error("rtt lines differ");
endmodule

bind spd_power_down spd_checker #(.DQ_W(DQ_W), .DM_W(DM_W)) spd_checker_i (.*);

// >>> spd_ctl_model.sv
// Memory controller model for the power-down and termination pins
module spd_ctl_model (
  input  wire logic pclk,
  output logic      cke        = 1'b1,
  output logic      odt        = 1'b0,
  output logic      cmd_nop    = 1'b1,
  output logic      banks_open = 1'b0,
  output logic      op_busy    = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin level, changed just after an edge
  task automatic set_odt(input logic v);
    odt <= v;
  endtask
  // Down with NOP past tCKE, junk on ignored pins, exit with NOP, then idle out tXPDLL
  task automatic pd_cycle(input logic bo, input int busy, hold);
    banks_open <= bo;
    op_busy    <= busy > 0;
    cke        <= 1'b0;
    for (int i = 0; i < hold; i++) begin
      @(posedge pclk);
      if (i == busy) op_busy <= 1'b0;
      if (i > busy + 5 && i < hold - 1) cmd_nop <= ~cmd_nop;
    end
    cmd_nop <= 1'b1;
    cke     <= 1'b1;
    repeat (16) @(posedge pclk);
  endtask
endmodule

// >>> spd_delay_timer.v
// Loadable down-counter that reports when a programmed delay has expired
module spd_delay_timer #(
  parameter W = 8
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         start,
  input  wire [W-1:0] count,
  output wire         done
);
  reg [W-1:0] remain;

  // Reload on start, else count down to zero and stay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= {W{1'b0}};
    end else if (start) begin
      remain <= count;
    end else if (remain != {W{1'b0}}) begin
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (remain == {W{1'b0}}) && !start;
endmodule

// >>> spd_map.vh
// Register map, field positions, reset values and timing counts for the power-down and termination block
`ifndef SPD_MAP_VH
`define SPD_MAP_VH
// Register byte offsets
`define SPD_CTRL_OFF      12'h000
`define SPD_MR_OFF        12'h004
`define SPD_TCKE_OFF      12'h008
`define SPD_TCPDED_OFF    12'h00C
`define SPD_TXP_OFF       12'h010
`define SPD_TXPDLL_OFF    12'h014
`define SPD_STATUS_OFF    12'h018
// Control register fields
`define SPD_CTRL_DLL_LOCK 0
`define SPD_CTRL_DLL_RST  1
`define SPD_CTRL_SREF     2
// Mode register mirror fields
`define SPD_MR_PPD_KEEP   0
`define SPD_MR_NOM_LO     1
`define SPD_MR_NOM_HI     3
`define SPD_MR_WR_LO      4
`define SPD_MR_WR_HI      5
// Status register fields
`define SPD_ST_STATE_LO   0
`define SPD_ST_STATE_HI   2
`define SPD_ST_DLL_ON     3
`define SPD_ST_RTT_ON     4
`define SPD_ST_CA_ON      5
`define SPD_ST_ANY_OK     6
`define SPD_ST_DLL_OK     7
`define SPD_ST_BUF_ON     8
`define SPD_ST_DLL_RSTREQ 9
// Reset values
`define SPD_CTRL_RST      32'h0000_0001
`define SPD_MR_RST        32'h0000_0000
// Timing counts in clock cycles
`define SPD_TCKE_CYC      8'h03
`define SPD_TCPDED_CYC    8'h01
`define SPD_TXP_CYC       8'h03
`define SPD_TXPDLL_CYC    8'h0A
`endif

// >>> spd_power_down.v
// Power-down entry and exit control with the basic on-die termination switch
`include "spd_map.vh"

module spd_power_down #(
  parameter DQ_W = 16,
  parameter DM_W = 2
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire            cke,
  input  wire            odt,
  input  wire            cmd_nop,
  input  wire            banks_open,
  input  wire            op_busy,
  output reg             power_down_state,
  output reg             cmd_rx_on,
  output reg             buf_on,
  output reg             dll_on,
  output reg             any_cmd_ok,
  output reg             dll_cmd_ok,
  output reg  [DQ_W-1:0] rtt_dq_on,
  output reg  [1:0]      rtt_dqs_on,
  output reg  [DM_W-1:0] rtt_dm_on,
  output reg  [2:0]      rtt_nom_sel,
  output reg  [1:0]      rtt_wr_sel
);
  // State codes
  localparam ST_IDLE = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_PPD  = 3'd2;
  localparam ST_APD  = 3'd3;
  localparam ST_EXIT = 3'd4;

  reg [31:0] ctrl;
  reg [31:0] mr;
  reg [7:0]  t_cke;
  reg [7:0]  t_cpded;
  reg [7:0]  t_xp;
  reg [7:0]  t_xpdll;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg        slow_exit;
  reg        dll_rst_req;
  reg        entry_unlocked;
  wire       ppd_keep;
  wire [2:0] nom_field;
  wire [1:0] wr_field;
  wire       sref;
  wire       dll_locked;
  wire       rtt_en;
  wire       rtt_next;
  wire       cpded_done;
  wire       xp_done;
  wire       xpdll_done;
  wire       cke_done;
  wire       entry;
  wire       exit_ev;
  wire       wr_acc;
  wire       rd_acc;
  wire [3:0] ctrl_lo;

  assign ppd_keep   = mr[`SPD_MR_PPD_KEEP];
  assign nom_field  = mr[`SPD_MR_NOM_HI:`SPD_MR_NOM_LO];
  assign wr_field   = mr[`SPD_MR_WR_HI:`SPD_MR_WR_LO];
  assign sref       = ctrl[`SPD_CTRL_SREF];
  assign dll_locked = ctrl[`SPD_CTRL_DLL_LOCK];
  assign ctrl_lo    = ctrl[3:0];
  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;

  // Entry needs NOP/DES beside the falling CKE; exit the same with CKE high
  assign entry   = (state == ST_IDLE) && !cke && cmd_nop;
  assign exit_ev = ((state == ST_PPD) || (state == ST_APD)) && cke && cmd_nop && cke_done;

  // Delay counters for receiver shutoff, exit latencies and minimum CKE time
  spd_delay_timer #(.W(8)) u_cpded (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (entry),
    .count   (t_cpded),
    .done    (cpded_done)
  );
  spd_delay_timer #(.W(8)) u_xp (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (exit_ev),
    .count   (t_xp),
    .done    (xp_done)
  );
  spd_delay_timer #(.W(8)) u_xpdll (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (exit_ev),
    .count   (t_xpdll),
    .done    (xpdll_done)
  );
  spd_delay_timer #(.W(8)) u_cke (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (entry),
    .count   (t_cke),
    .done    (cke_done)
  );

  // Next state: CKE may fall mid-operation, the mode is settled once it drains
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (entry) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!op_busy) begin
          next_state = banks_open ? ST_APD : ST_PPD;
        end
      end
      ST_PPD, ST_APD: begin
        if (exit_ev) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (slow_exit ? xpdll_done : xp_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register; the async reset pin also pulls the block out of power-down
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Exit speed chosen at mode entry, and DLL-reset need remembered past exit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_exit      <= 1'b0;
      entry_unlocked <= 1'b0;
      dll_rst_req    <= 1'b0;
    end else begin
      if (state == ST_WAIT && !op_busy) begin
        slow_exit <= !banks_open && !ppd_keep;
      end
      if (entry) begin
        entry_unlocked <= !dll_locked;
      end
      // Set wins over the software clear
      if (exit_ev && entry_unlocked) begin
        dll_rst_req <= 1'b1;
      end else if (wr_acc && paddr == `SPD_CTRL_OFF && pwdata[`SPD_CTRL_DLL_RST]) begin
        dll_rst_req <= 1'b0;
      end
    end
  end

  // Termination: pin gated by mode fields, self-refresh, DLL state and slow-exit precharge power-down
  assign rtt_en   = (nom_field != 3'b000) || (wr_field != 2'b00);
  assign rtt_next = odt && rtt_en && !sref && dll_locked &&
                    !(state == ST_PPD && slow_exit);

  // Pin-side outputs all come from flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_state <= 1'b0;
      cmd_rx_on        <= 1'b1;
      buf_on           <= 1'b1;
      dll_on           <= 1'b1;
      any_cmd_ok       <= 1'b1;
      dll_cmd_ok       <= 1'b1;
      rtt_dq_on        <= {DQ_W{1'b0}};
      rtt_dqs_on       <= 2'b00;
      rtt_dm_on        <= {DM_W{1'b0}};
      rtt_nom_sel      <= 3'b000;
      rtt_wr_sel       <= 2'b00;
    end else begin
      power_down_state <= (next_state == ST_PPD) || (next_state == ST_APD);
      // Receivers stay live through tCPDED so trailing NOPs are still seen
      cmd_rx_on  <= !((next_state != ST_IDLE) && (next_state != ST_EXIT) && cpded_done);
      buf_on     <= !((next_state == ST_PPD) || (next_state == ST_APD));
      dll_on     <= dll_locked && !(next_state == ST_PPD && !ppd_keep);
      any_cmd_ok <= (next_state == ST_IDLE) || (next_state == ST_EXIT && xp_done);
      dll_cmd_ok <= (next_state == ST_IDLE) && !dll_rst_req;
      rtt_dq_on  <= {DQ_W{rtt_next}};
      rtt_dqs_on <= {2{rtt_next}};
      rtt_dm_on  <= {DM_W{rtt_next}};
      rtt_nom_sel <= nom_field;
      rtt_wr_sel  <= wr_field;
    end
  end

  // Software registers; timing counts reset to their documented cycle figures
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= `SPD_CTRL_RST;
      mr      <= `SPD_MR_RST;
      t_cke   <= `SPD_TCKE_CYC;
      t_cpded <= `SPD_TCPDED_CYC;
      t_xp    <= `SPD_TXP_CYC;
      t_xpdll <= `SPD_TXPDLL_CYC;
    end else if (wr_acc) begin
      case (paddr)
        `SPD_CTRL_OFF:   ctrl    <= {28'h000_0000, pwdata[3:2], 1'b0, pwdata[0]};
        `SPD_MR_OFF:     mr      <= {26'h000_0000, pwdata[5:0]};
        `SPD_TCKE_OFF:   t_cke   <= pwdata[7:0];
        `SPD_TCPDED_OFF: t_cpded <= pwdata[7:0];
        `SPD_TXP_OFF:    t_xp    <= pwdata[7:0];
        `SPD_TXPDLL_OFF: t_xpdll <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // APB answer: one-cycle access phase, error on unmapped offsets
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `SPD_CTRL_OFF:   prdata <= {28'h000_0000, ctrl_lo};
          `SPD_MR_OFF:     prdata <= mr;
          `SPD_TCKE_OFF:   prdata <= {24'h00_0000, t_cke};
          `SPD_TCPDED_OFF: prdata <= {24'h00_0000, t_cpded};
          `SPD_TXP_OFF:    prdata <= {24'h00_0000, t_xp};
          `SPD_TXPDLL_OFF: prdata <= {24'h00_0000, t_xpdll};
          `SPD_STATUS_OFF: prdata <= {22'h00_0000, dll_rst_req, buf_on, dll_cmd_ok,
                                      any_cmd_ok, cmd_rx_on, rtt_dqs_on[0], dll_on, state};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Unused read strobe kept for symmetry of decode
  wire unused_rd = rd_acc;
endmodule

// >>> spd_power_down_bench.sv
// Self-checking bench for the power-down and termination block
`include "spd_map.vh"
module spd_power_down_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [31:0] rst_tab [6] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0003, 32'h0000_0001,
                               32'h0000_0003, 32'h0000_000A};
  wire  [31:0] prdata;
  wire         pready, pslverr, cke, odt, cmd_nop, banks_open, op_busy, power_down_state;
  wire         cmd_rx_on, buf_on, dll_on, any_cmd_ok, dll_cmd_ok;
  wire  [15:0] rtt_dq_on;
  wire  [2:0]  rtt_nom_sel;
  wire  [1:0]  rtt_dqs_on, rtt_dm_on, rtt_wr_sel;
  int          bad_count = 0, num_checks = 0, i;
  spd_power_down spd_power_down_i (.*);
  spd_ctl_model spd_ctl_model_i (.*);
  // 250 MHz clock
  always #2 pclk = ~pclk;
  // Verdict, also reached by a timeout
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, held until pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken only at the edge where pready is seen high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up;
    end
    @(posedge pclk);
  endtask
  // Termination under one control, mode and pin setting
  task automatic odt_case(input logic [31:0] ctl, mr, input logic o, exp);
    apb(1'b1, `SPD_CTRL_OFF, ctl);
    apb(1'b1, `SPD_MR_OFF, mr);
    spd_ctl_model_i.set_odt(o);
    repeat (2) @(posedge pclk);
    #1;
    check("rtt", 32'({rtt_dq_on, rtt_dqs_on, rtt_dm_on}), 32'({20{exp}}));
    check("rtt_sel", 32'({rtt_nom_sel, rtt_wr_sel}), 32'({mr[3:1], mr[5:4]}));
    @(posedge pclk);
  endtask
  // One visit: status while down, command gates after exit
  task automatic pd_test(input logic bo, keep, input int busy, input logic dll);
    apb(1'b1, `SPD_MR_OFF, {31'h0000_0000, keep});
    fork
      spd_ctl_model_i.pd_cycle(bo, busy, busy + 14);
      begin
        repeat (busy + 7) @(posedge pclk);
        apb(1'b0, `SPD_STATUS_OFF, 32'h0000_0000);
        #1;
        check("pd", 32'(power_down_state), 32'h0000_0001);
        check("pd_st", 32'({rd[8], rd[5], rd[4], rd[3]}), 32'({3'b000, dll}));
      end
    join
    #1;
    check("exit", 32'({power_down_state, buf_on, cmd_rx_on, dll_on, any_cmd_ok, dll_cmd_ok}), 32'h0000_001F);
    @(posedge pclk);
    $display("power-down visit done");
  endtask
  // Reset, registers, termination table, three visits, reset while down
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      check("reg", rd, rst_tab[i]);
    end
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check("unmapped", {rd[30:0], err}, 32'h0000_0001);
    $display("registers done");
    odt_case(32'h0000_0001, 32'h0000_0002, 1'b1, 1'b1);
    odt_case(32'h0000_0001, 32'h0000_0030, 1'b1, 1'b1);
    odt_case(32'h0000_0001, 32'h0000_0002, 1'b0, 1'b0);
    odt_case(32'h0000_0001, 32'h0000_0000, 1'b1, 1'b0);
    odt_case(32'h0000_0005, 32'h0000_000E, 1'b1, 1'b0);
    odt_case(32'h0000_0000, 32'h0000_000E, 1'b1, 1'b0);
    odt_case(32'h0000_0001, 32'h0000_0000, 1'b0, 1'b0);
    $display("termination done");
    pd_test(1'b1, 1'b0, 0, 1'b1);
    pd_test(1'b0, 1'b0, 3, 1'b0);
    pd_test(1'b0, 1'b1, 0, 1'b1);
    fork
      spd_ctl_model_i.pd_cycle(1'b0, 0, 20);
      begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        check("rst_pd", 32'({power_down_state, buf_on}), 32'h0000_0001);
        @(posedge pclk);
        presetn <= 1'b1;
      end
    join
    apb(1'b0, `SPD_MR_OFF, 32'h0000_0000);
    check("rst_mr", rd, 32'h0000_0000);
    $display("reset while down done");
    wrap_up;
  end
endmodule
